//--- rtl/ros_bank.sv
// Remappable output select bank: five code registers and ten pin muxes
`timescale 1ns/1ps
// Summary of operation
// RL1: Bits 15..14 unimplemented, read zero
// RL2: Bits 7..6 unimplemented, read zero
// RL3: Upper field selects odd pin function
// RL4: Lower field selects even pin function
// RL5: Fields read back written value
// RL6: Fields reset zero; code routes peripheral
module ros_bank
    import ros_pkg::*;
(
    input  wire logic                    i_clk,
    input  wire logic                    i_rst,
    input  wire logic [ROS_ADDR_W-1:0]   i_addr,     // Register index
    input  wire logic [ROS_DATA_W-1:0]   i_wdata,    // Write data
    input  wire logic                    i_wr,       // Write strobe
    input  wire logic                    i_rd,       // Read strobe
    input  wire logic [ROS_FUNC_N-1:0]   i_periph,   // Peripheral output functions
    output logic      [ROS_DATA_W-1:0]   o_rdata,    // Read data, cycle after i_rd
    output logic      [ROS_NUM_PINS-1:0] o_pins      // Pins 38..47, bit 0 is pin 38
);

    ros_req_s                  req;                  // Bundled bus request
    ros_pair_s [ROS_NUM_REGS-1:0] codes;             // Stored code pairs
    ros_pair_s [ROS_NUM_REGS-1:0] next_codes;        // Next code pairs
    logic      [ROS_DATA_W-1:0]   next_rdata;        // Next read data
    logic      [5:0]              pin_code [ROS_NUM_PINS];  // Code per pin

    assign req = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

    // Write path: only the two code fields take data
    always_comb begin
        next_codes = codes;
        if (req.wr && (req.addr <= ROS_IDX_P46_47)) begin
            // Unimplemented bits are simply not captured
            next_codes[req.addr].odd_code  =
                req.wdata[ROS_HI_LSB +: ROS_CODE_W];                      // see RL3 see RL5
            next_codes[req.addr].even_code =
                req.wdata[ROS_LO_LSB +: ROS_CODE_W];                      // see RL4 see RL5
        end
    end

    // Read path: reserved bits forced zero, unmapped index reads zero
    always_comb begin
        next_rdata = ROS_RD_ZERO;
        if (req.rd && (req.addr <= ROS_IDX_P46_47)) begin
            next_rdata[ROS_HI_LSB +: ROS_CODE_W] = codes[req.addr].odd_code;  // see RL1
            next_rdata[ROS_LO_LSB +: ROS_CODE_W] = codes[req.addr].even_code; // see RL2
        end
    end

    // Register state; read data holds only the cycle after a read
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            codes   <= '0;                                                // see RL6
            o_rdata <= ROS_RD_ZERO;
        end else begin
            codes   <= next_codes;
            o_rdata <= next_rdata;
        end
    end

    // Pin 2k takes lower field of register k, pin 2k+1 the upper
    for (genvar k = 0; k < ROS_NUM_REGS; k++) begin : g_map
        assign pin_code[2*k]   = codes[k].even_code;                      // see RL4
        assign pin_code[2*k+1] = codes[k].odd_code;                       // see RL3
    end

    // One mux per pin; the mux registers its output
    for (genvar p = 0; p < ROS_NUM_PINS; p++) begin : g_pin
        ros_pin_mux u_mux (
            .i_clk    (i_clk),
            .i_rst    (i_rst),
            .i_code   (pin_code[p]),
            .i_periph (i_periph),
            .o_pin    (o_pins[p])                                         // see RL6
        );
    end

    // Upper reserved bits never read as one
    a_rsv_high_zero: assert property ( // see RL1
        @(posedge i_clk) disable iff (i_rst)
        o_rdata[15:14] == 2'b00)
        else $error("reserved bits 15..14 read nonzero");

    // Middle reserved bits never read as one
    a_rsv_mid_zero: assert property ( // see RL2
        @(posedge i_clk) disable iff (i_rst)
        o_rdata[7:6] == 2'b00)
        else $error("reserved bits 7..6 read nonzero");

    // Written upper field lands on odd pin code
    a_odd_write: assert property ( // see RL3
        @(posedge i_clk) disable iff (i_rst)
        (i_wr && i_addr <= ROS_IDX_P46_47) |=>
        (codes[$past(i_addr)].odd_code == $past(i_wdata[13:8])))
        else $error("odd pin code not stored");

    // Written lower field lands on even pin code
    a_even_write: assert property ( // see RL4
        @(posedge i_clk) disable iff (i_rst)
        (i_wr && i_addr <= ROS_IDX_P46_47) |=>
        (codes[$past(i_addr)].even_code == $past(i_wdata[5:0])))
        else $error("even pin code not stored");

    // Read returns stored fields one cycle later
    a_read_back: assert property ( // see RL5
        @(posedge i_clk) disable iff (i_rst)
        (i_rd && i_addr <= ROS_IDX_P46_47 && !i_wr) |=>
        (o_rdata == {2'b00, $past(codes[i_addr].odd_code),
                     2'b00, $past(codes[i_addr].even_code)}))
        else $error("read data does not match stored fields");

    // Outside a read cycle the read data is zero
    a_rdata_idle: assert property ( // see RL5
        @(posedge i_clk) disable iff (i_rst)
        !i_rd |=> (o_rdata == ROS_RD_ZERO))
        else $error("read data not zero after idle cycle");

    // Unmapped index reads back zero
    a_unmapped_read: assert property ( // see RL5
        @(posedge i_clk) disable iff (i_rst)
        (i_rd && i_addr > ROS_IDX_P46_47) |=> (o_rdata == ROS_RD_ZERO))
        else $error("unmapped index read nonzero");

    // Codes change only through a mapped write
    a_codes_hold: assert property ( // see RL5
        @(posedge i_clk) disable iff (i_rst)
        (!i_wr || i_addr > ROS_IDX_P46_47) |=> (codes == $past(codes)))
        else $error("codes changed without a mapped write");

    // Reset leaves codes, read data and pins cleared
    a_reset_clear: assert property ( // see RL6
        @(posedge i_clk)
        i_rst |=> ((codes == '0) && (o_rdata == ROS_RD_ZERO) && (o_pins == '0)))
        else $error("state not cleared by reset");

    // Pin 38 follows the lower field of the first register
    a_pin38_route: assert property ( // see RL4 see RL6
        @(posedge i_clk) disable iff (i_rst)
        (codes[0].even_code != ROS_CODE_RST) |=>
        (o_pins[0] == $past(i_periph[codes[0].even_code])))
        else $error("pin 38 not routed to selected function");

    // Pin 39 follows the upper field of the first register
    a_pin39_route: assert property ( // see RL3 see RL6
        @(posedge i_clk) disable iff (i_rst)
        (codes[0].odd_code != ROS_CODE_RST) |=>
        (o_pins[1] == $past(i_periph[codes[0].odd_code])))
        else $error("pin 39 not routed to selected function");

    // Pin 40 follows the lower field of the second register
    a_pin40_route: assert property ( // see RL4 see RL6
        @(posedge i_clk) disable iff (i_rst)
        (codes[1].even_code != ROS_CODE_RST) |=>
        (o_pins[2] == $past(i_periph[codes[1].even_code])))
        else $error("pin 40 not routed to selected function");

    // Pin 41 follows the upper field of the second register
    a_pin41_route: assert property ( // see RL3 see RL6
        @(posedge i_clk) disable iff (i_rst)
        (codes[1].odd_code != ROS_CODE_RST) |=>
        (o_pins[3] == $past(i_periph[codes[1].odd_code])))
        else $error("pin 41 not routed to selected function");

    // Pin 42 follows the lower field of the third register
    a_pin42_route: assert property ( // see RL4 see RL6
        @(posedge i_clk) disable iff (i_rst)
        (codes[2].even_code != ROS_CODE_RST) |=>
        (o_pins[4] == $past(i_periph[codes[2].even_code])))
        else $error("pin 42 not routed to selected function");

    // Pin 43 follows the upper field of the third register
    a_pin43_route: assert property ( // see RL3 see RL6
        @(posedge i_clk) disable iff (i_rst)
        (codes[2].odd_code != ROS_CODE_RST) |=>
        (o_pins[5] == $past(i_periph[codes[2].odd_code])))
        else $error("pin 43 not routed to selected function");

    // Pin 44 follows the lower field of the fourth register
    a_pin44_route: assert property ( // see RL4 see RL6
        @(posedge i_clk) disable iff (i_rst)
        (codes[3].even_code != ROS_CODE_RST) |=>
        (o_pins[6] == $past(i_periph[codes[3].even_code])))
        else $error("pin 44 not routed to selected function");

    // Pin 45 follows the upper field of the fourth register
    a_pin45_route: assert property ( // see RL3 see RL6
        @(posedge i_clk) disable iff (i_rst)
        (codes[3].odd_code != ROS_CODE_RST) |=>
        (o_pins[7] == $past(i_periph[codes[3].odd_code])))
        else $error("pin 45 not routed to selected function");

    // Pin 46 follows the lower field of the fifth register
    a_pin46_route: assert property ( // see RL4 see RL6
        @(posedge i_clk) disable iff (i_rst)
        (codes[4].even_code != ROS_CODE_RST) |=>
        (o_pins[8] == $past(i_periph[codes[4].even_code])))
        else $error("pin 46 not routed to selected function");

    // Pin 47 follows the upper field of the fifth register
    a_pin47_route: assert property ( // see RL3 see RL6
        @(posedge i_clk) disable iff (i_rst)
        (codes[4].odd_code != ROS_CODE_RST) |=>
        (o_pins[9] == $past(i_periph[codes[4].odd_code])))
        else $error("pin 47 not routed to selected function");

    // Code zero parks pin 38 low, even though function line 0 may toggle
    a_pin38_park: assert property ( // see RL6
        @(posedge i_clk) disable iff (i_rst)
        (codes[0].even_code == ROS_CODE_RST) |=> !o_pins[0])
        else $error("pin 38 driven while unassigned");

    // Code zero parks pin 47 low
    a_pin47_park: assert property ( // see RL6
        @(posedge i_clk) disable iff (i_rst)
        (codes[4].odd_code == ROS_CODE_RST) |=> !o_pins[9])
        else $error("pin 47 driven while unassigned");

endmodule : ros_bank

//--- rtl/ros_pin_mux.sv
// One remappable pin: selects a peripheral output by function code
`timescale 1ns/1ps
module ros_pin_mux
    import ros_pkg::*;
(
    input  wire logic                  i_clk,
    input  wire logic                  i_rst,
    input  wire logic [5:0]            i_code,    // Selected function code
    input  wire logic [ROS_FUNC_N-1:0] i_periph,  // All peripheral outputs
    output logic                       o_pin      // Registered pin level
);

    logic next_pin;  // Combinational selection

    // Code zero means no function: pin parks low
    always_comb begin
        next_pin = (i_code == ROS_CODE_RST) ? 1'b0 : i_periph[i_code];  // see RL6
    end

    // Register the pin so the top output comes from a flop
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_pin <= 1'b0;
        end else begin
            o_pin <= next_pin;
        end
    end

endmodule : ros_pin_mux

//--- rtl/ros_pkg.sv
// Package for the remappable output select bank: map, fields, widths
package ros_pkg;

    // Bus and register geometry
    localparam int          ROS_DATA_W     = 16;       // Register width
    localparam int          ROS_ADDR_W     = 3;        // Register index width
    localparam int          ROS_NUM_REGS   = 5;        // Registers in the bank
    localparam int          ROS_NUM_PINS   = 10;       // Pins 38..47
    localparam int          ROS_CODE_W     = 6;        // Function code width
    localparam int          ROS_FUNC_N     = 64;       // Peripheral output lines; codes 1..63 select one
    localparam int          ROS_FIRST_PIN  = 38;       // Lowest pin number served

    // Field positions inside each register
    localparam int          ROS_LO_LSB     = 0;        // Even pin code, bits 5..0
    localparam int          ROS_HI_LSB     = 8;        // Odd pin code, bits 13..8

    // Register indices (index = word offset)
    localparam logic [2:0]  ROS_IDX_P38_39 = 3'h0;
    localparam logic [2:0]  ROS_IDX_P40_41 = 3'h1;
    localparam logic [2:0]  ROS_IDX_P42_43 = 3'h2;
    localparam logic [2:0]  ROS_IDX_P44_45 = 3'h3;
    localparam logic [2:0]  ROS_IDX_P46_47 = 3'h4;

    // Reset value of a function code and of unmapped reads
    localparam logic [5:0]  ROS_CODE_RST   = 6'h00;
    localparam logic [15:0] ROS_RD_ZERO    = 16'h0000;

    // Code pair held by one register
    typedef struct packed {
        logic [5:0] odd_code;   // Upper field, odd pin
        logic [5:0] even_code;  // Lower field, even pin
    } ros_pair_s;

    // Register bus request
    typedef struct packed {
        logic [2:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } ros_req_s;

endpackage : ros_pkg

//--- tb/ros_bank_tb.sv
// Self-checking bench for the remappable output select bank
`timescale 1ns/1ps
module ros_bank_tb;
    import ros_pkg::*;
    logic        i_clk = 0, i_rst = 1, i_wr = 0, i_rd = 0;
    logic [2:0]  i_addr = 0;                  // Register index
    logic [15:0] i_wdata = 0, o_rdata, rdat;  // Bus data and last read
    logic [63:0] i_periph;                    // From the model
    logic [9:0]  o_pins, e;                   // Pins and their expectation
    int          n_errors = 0, checks_done = 0;
    ros_bank uut (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .i_periph(i_periph), .o_rdata(o_rdata), .o_pins(o_pins));
    ros_periph_model model (.i_clk(i_clk), .i_rst(i_rst), .o_periph(i_periph));
    initial begin
        forever #5 i_clk = ~i_clk;
    end
    task chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // One strobe cycle; read data are caught in the single cycle they stand
    task bus(input logic wr, input logic rd, input logic [2:0] a, input logic [15:0] d);
        @(posedge i_clk);
        {i_wr, i_rd, i_addr, i_wdata} <= {wr, rd, a, d};
        @(posedge i_clk);
        {i_wr, i_rd} <= 2'b00;
        #1 rdat = o_rdata;
    endtask : bus
    // Fresh codes read zero and park every pin low
    task t_reset;
        for (int k = 0; k < 5; k++) begin
            bus(0, 1, 3'(k), 16'h0000);
            chk(rdat, 16'h0000);
        end
        chk({6'h00, o_pins}, 16'h0000);
    endtask : t_reset
    // Only the two code fields hold what is written
    task t_fields;
        for (int k = 0; k < 8; k++) begin
            bus(1, 0, 3'(k), 16'hFFFF);
            bus(0, 1, 3'(k), 16'h0000);
            chk(rdat, (k < 5) ? 16'h3F3F : 16'h0000);
            bus(1, 0, 3'(k), 16'hC0C0);
            bus(0, 1, 3'(k), 16'h0000);
            chk(rdat, 16'h0000);
        end
    endtask : t_fields
    // Distinct codes per pin; each pin must follow its own function line
    task t_route;
        for (int k = 0; k < 5; k++) begin
            bus(1, 0, 3'(k), {2'b11, 6'(2*k+11), 2'b11, 6'(2*k+1)});
            bus(0, 1, 3'(k), 16'h0000);
            chk(rdat, {2'b00, 6'(2*k+11), 2'b00, 6'(2*k+1)});
        end
        repeat (2) @(posedge i_clk);
        for (int c = 0; c < 4; c++) begin
            @(negedge i_clk);
            for (int p = 0; p < 10; p++) begin
                e[p] = i_periph[(p % 2) ? (p - 1 + 11) : (p + 1)];
            end
            @(posedge i_clk);
            #1 chk({6'h00, o_pins}, {6'h00, e});
        end
        // Mid-run reset must clear the codes just written
        @(posedge i_clk);
        i_rst <= 1;
        @(posedge i_clk);
        i_rst <= 0;
        bus(0, 1, 3'(4), 16'h0000);
        chk(rdat, 16'h0000);
        chk({6'h00, o_pins}, 16'h0000);
    endtask : t_route
    task end_of_test;
        if (n_errors == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_of_test
    initial begin
        repeat (4) @(posedge i_clk);
        i_rst <= 0;
        t_reset();
        t_fields();
        t_route();
        end_of_test();
    end
endmodule : ros_bank_tb

//--- tb/ros_periph_model.sv
// Peripheral output model feeding the function lines of the bank
`timescale 1ns/1ps
module ros_periph_model
    import ros_pkg::*;
(
    input  wire logic                  i_clk,
    input  wire logic                  i_rst,
    output logic      [ROS_FUNC_N-1:0] o_periph  // Bit n is function code n
);
    // Pattern churns every rising edge, so a pin sampling a stale line shows up
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_periph <= 64'hA5A5_5A5A_3C3C_C3C3;
        end else begin
            o_periph <= ~o_periph ^ {o_periph[0], o_periph[63:1]};
        end
    end
endmodule : ros_periph_model
